// ===== timer_pair_pkg.sv
// Purpose: constants and types for the dual 8-bit timer pair
// Assumes: apb slave, 32-bit data, one word per register
// Notes:   prescaler taps arrive as one-cycle enable pulses
package timer_pair_pkg;
    localparam logic [11:0] run_off     = 12'h000;
    localparam logic [11:0] mode_off    = 12'h004;
    localparam logic [11:0] ffctl_off   = 12'h008;
    localparam logic [11:0] lcmp_off    = 12'h00c;
    localparam logic [11:0] ucmp_off    = 12'h010;
    localparam logic [11:0] status_off  = 12'h014;
    localparam logic [11:0] count_off   = 12'h018;

    localparam logic [1:0] mode_dual  = 2'h0;
    localparam logic [1:0] mode_16    = 2'h1;
    localparam logic [1:0] mode_ppg   = 2'h2;
    localparam logic [1:0] mode_pwm   = 2'h3;

    localparam logic [1:0] ffc_invert = 2'h0;
    localparam logic [1:0] ffc_set    = 2'h1;
    localparam logic [1:0] ffc_clear  = 2'h2;
    localparam logic [1:0] ffc_keep   = 2'h3;

    localparam logic [1:0] pwm_n6     = 2'h1;
    localparam logic [1:0] pwm_n7     = 2'h2;
    localparam logic [7:0] top_n6     = 8'h3f;
    localparam logic [7:0] top_n7     = 8'h7f;
    localparam logic [7:0] top_n8     = 8'hff;

    localparam logic [1:0] ffc_reset  = 2'h3;
    localparam logic [7:0] zero8      = 8'h00;
    localparam logic [7:0] one8       = 8'h01;

    // run: [0] lower run, [1] upper run
    // mode: [1:0] lower clk, [3:2] upper clk, [5:4] pwm cycle, [7:6] mode
    // ffctl: [0] source select, [1] invert en, [3:2] ff control, [4] dbuf
    typedef struct packed {
        logic [1:0] pair_mode;
        logic [1:0] pwm_cycle;
        logic [1:0] upper_clk;
        logic [1:0] lower_clk;
    } mode_t;

    typedef struct packed {
        logic       dbuf_en;
        logic [1:0] ff_ctl;
        logic       inv_en;
        logic       src_sel;
    } ffcfg_t;

    typedef struct packed {
        logic tap_1;
        logic tap_4;
        logic tap_16;
        logic tap_256;
    } taps_t;
endpackage

// ===== timer_pair.sv
// Purpose: dual 8-bit timer pair with 16-bit, pulse and pwm modes
// Assumes: apb slave on pclk; taps are enables, external clock is sampled on pclk and counts on its rising edge
// Notes:   register writes are single-cycle, pready always high
//
// Notes on behaviour
// RULE1: in dual mode each 8-bit timer runs independently as interval timer
// RULE2: software stops a timer before changing mode, clock or compare
// RULE3: clearing a run bit stops that timer and zeroes its counter
// RULE4: lower clock is pin or taps 1,4,16; upper is match or 1,16,256
// RULE5: with inversion enabled the flip-flop toggles each period onto pin
// RULE6: in dual mode upper may count on each lower compare match
// RULE7: mode field 01 cascades both timers into one 16-bit timer
// RULE8: in 16-bit mode upper clocks from lower match, ignoring select
// RULE9: 16-bit: low compare write disables compare, high write enables
// RULE10: 16-bit: lower match does not clear counter nor raise interrupt
// RULE11: 16-bit: joint match clears both, raises upper irq, may toggle
// RULE12: pulse mode lower timer drives programmable wave, upper unused
// RULE13: pulse mode inverts output when lower counter hits either compare
// RULE14: pulse mode software keeps lower compare below upper compare
// RULE15: pulse mode software still sets upper run bit
// RULE16: pulse mode double buffer loads lower compare on upper match
// RULE17: pwm only on lower timer, 8-bit, upper remains an 8-bit timer
// RULE18: pwm inverts on compare match or 2^n overflow, clears on overflow
// RULE19: pwm software sets lower compare nonzero and below 2^n
// RULE20: pwm double buffer loads lower compare on each overflow
// RULE21: dual mode each timer clears on match and raises its interrupt
// RULE22: mode field 00 dual, 01 16-bit, 10 pulse, 11 pwm
// RULE23: pwm cycle field 01,10,11 selects 2^6, 2^7, 2^8
// RULE24: dual mode source select 0 lower, 1 upper toggles flip-flop
// RULE25: ff control write 00 inverts, 01 sets, 10 clears, 11 holds
`timescale 1ns/1ps
`default_nettype none
module timer_pair (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire timer_pair_pkg::taps_t taps,
    input  wire logic                 external_clock_pin,
    output logic                      timer_output_pin,
    output logic                      lower_timer_irq,
    output logic                      upper_timer_irq
);
    logic                   lrun_ff, urun_ff, nxt_lrun, nxt_urun;
    timer_pair_pkg::mode_t  mode_ff, nxt_mode;
    timer_pair_pkg::ffcfg_t ffcfg_ff, nxt_ffcfg;
    logic [7:0]             lcmp_ff, nxt_lcmp, lbuf_ff, nxt_lbuf;
    logic [7:0]             ucmp_ff, nxt_ucmp;
    logic [7:0]             lcnt_ff, nxt_lcnt, ucnt_ff, nxt_ucnt;
    logic                   cmp_en_ff, nxt_cmp_en;
    logic                   ff_ff, nxt_ff;
    logic                   lirq_ff, nxt_lirq, uirq_ff, nxt_uirq;
    logic [31:0]            rdata_ff, nxt_rdata;
    logic                   ext_prev_ff, nxt_ext_prev;

    logic       wr, rd, lclk, uclk, lmatch, umatch, ovf, toggle;
    logic       lsel_match, pulse_hit;
    logic [7:0] pwm_top;

    function automatic logic lower_tick(input logic [1:0] sel,
                                        input logic ext_rise,
                                        input timer_pair_pkg::taps_t t);
        case (sel)
            2'h0:    lower_tick = ext_rise;
            2'h1:    lower_tick = t.tap_1;
            2'h2:    lower_tick = t.tap_4;
            default: lower_tick = t.tap_16;
        endcase
    endfunction

    // match on the tick that would reach the compare value: a compare of
    // n gives n ticks per period, and 0 gives a full 256
    function automatic logic next_hits(input logic [7:0] cnt,
                                       input logic [7:0] cmp);
        next_hits = (cnt + timer_pair_pkg::one8) == cmp;
    endfunction

    assign wr = psel && penable && pwrite;
    // latched in setup so prdata already stands through the access cycle
    assign rd = psel && !penable && !pwrite;

    always_comb begin
        nxt_ext_prev = external_clock_pin;
        // external pin counts on its rising edge
        lclk = lrun_ff && lower_tick(mode_ff.lower_clk,
                   external_clock_pin && !ext_prev_ff, taps); // RULE4
        lmatch = lclk && next_hits(lcnt_ff, lcmp_ff);
        case (mode_ff.pwm_cycle)                                // RULE23
            timer_pair_pkg::pwm_n6: pwm_top = timer_pair_pkg::top_n6;
            timer_pair_pkg::pwm_n7: pwm_top = timer_pair_pkg::top_n7;
            default:                pwm_top = timer_pair_pkg::top_n8;
        endcase
        ovf = (mode_ff.pair_mode == timer_pair_pkg::mode_pwm) && lclk
              && (lcnt_ff == pwm_top);
        pulse_hit = lclk && next_hits(lcnt_ff, ucmp_ff);
        // upper clock source
        if (mode_ff.pair_mode == timer_pair_pkg::mode_16) begin
            uclk = urun_ff && lmatch && cmp_en_ff;                 // RULE8
        end else begin
            case (mode_ff.upper_clk)                                // RULE4
                2'h0:    uclk = urun_ff && lmatch;                  // RULE6
                2'h1:    uclk = urun_ff && taps.tap_1;
                2'h2:    uclk = urun_ff && taps.tap_16;
                default: uclk = urun_ff && taps.tap_256;
            endcase
        end
        umatch = uclk && next_hits(ucnt_ff, ucmp_ff);
        lsel_match = 1'b0;
        toggle = 1'b0;
        nxt_lcnt = lcnt_ff;
        nxt_ucnt = ucnt_ff;
        nxt_lirq = 1'b0;
        nxt_uirq = 1'b0;
        nxt_lcmp = lcmp_ff;
        case (mode_ff.pair_mode)                                    // RULE22
            timer_pair_pkg::mode_dual: begin                        // RULE1
                if (lclk) begin
                    nxt_lcnt = lmatch ? timer_pair_pkg::zero8
                                      : lcnt_ff + timer_pair_pkg::one8;
                end
                if (uclk) begin
                    nxt_ucnt = umatch ? timer_pair_pkg::zero8
                                      : ucnt_ff + timer_pair_pkg::one8;
                end
                nxt_lirq = lmatch;                                  // RULE21
                nxt_uirq = umatch;                                  // RULE21
                lsel_match = ffcfg_ff.src_sel ? umatch : lmatch;    // RULE24
                toggle = lsel_match;                                // RULE5
            end
            timer_pair_pkg::mode_16: begin                          // RULE7
                // lower keeps counting through its match
                if (lclk) begin
                    nxt_lcnt = lcnt_ff + timer_pair_pkg::one8;      // RULE10
                end
                if (uclk) begin
                    nxt_ucnt = ucnt_ff + timer_pair_pkg::one8;
                end
                // upper holds whole lower periods, so it compares as is
                if (cmp_en_ff && lmatch
                    && (ucnt_ff == ucmp_ff)) begin                  // RULE11
                    nxt_lcnt = timer_pair_pkg::zero8;
                    nxt_ucnt = timer_pair_pkg::zero8;
                    nxt_uirq = 1'b1;
                    toggle = 1'b1;
                end
            end
            timer_pair_pkg::mode_ppg: begin                         // RULE12
                if (lclk) begin
                    nxt_lcnt = pulse_hit ? timer_pair_pkg::zero8
                                         : lcnt_ff + timer_pair_pkg::one8;
                end
                toggle = lmatch || pulse_hit;                       // RULE13
                if (pulse_hit && ffcfg_ff.dbuf_en) begin
                    nxt_lcmp = lbuf_ff;                             // RULE16
                end
            end
            default: begin                                          // RULE17
                if (lclk) begin
                    nxt_lcnt = ovf ? timer_pair_pkg::zero8
                                   : lcnt_ff + timer_pair_pkg::one8; // RULE18
                end
                toggle = lmatch || ovf;                             // RULE18
                if (ovf && ffcfg_ff.dbuf_en) begin
                    nxt_lcmp = lbuf_ff;                             // RULE20
                end
                if (uclk) begin
                    nxt_ucnt = umatch ? timer_pair_pkg::zero8
                                      : ucnt_ff + timer_pair_pkg::one8;
                end
                nxt_uirq = umatch;
            end
        endcase
        if (!lrun_ff) begin
            nxt_lcnt = timer_pair_pkg::zero8;                       // RULE3
        end
        if (!urun_ff) begin
            nxt_ucnt = timer_pair_pkg::zero8;                       // RULE3
        end
    end

    // register writes and flip-flop
    always_comb begin
        nxt_lrun   = lrun_ff;
        nxt_urun   = urun_ff;
        nxt_mode   = mode_ff;
        nxt_ffcfg  = ffcfg_ff;
        nxt_lbuf   = lbuf_ff;
        nxt_ucmp   = ucmp_ff;
        nxt_cmp_en = cmp_en_ff;
        nxt_ff     = (toggle && ffcfg_ff.inv_en) ? !ff_ff : ff_ff;  // RULE5
        nxt_rdata  = rdata_ff;
        if (wr) begin
            case (paddr)
                timer_pair_pkg::run_off: begin
                    nxt_lrun = pwdata[0];
                    nxt_urun = pwdata[1];
                end
                timer_pair_pkg::mode_off: begin
                    nxt_mode = timer_pair_pkg::mode_t'(pwdata[7:0]);
                end
                timer_pair_pkg::ffctl_off: begin
                    nxt_ffcfg = timer_pair_pkg::ffcfg_t'(pwdata[4:0]);
                    case (pwdata[3:2])                              // RULE25
                        timer_pair_pkg::ffc_invert: nxt_ff = !ff_ff;
                        timer_pair_pkg::ffc_set:    nxt_ff = 1'b1;
                        timer_pair_pkg::ffc_clear:  nxt_ff = 1'b0;
                        default:                    nxt_ff = ff_ff;
                    endcase
                end
                timer_pair_pkg::lcmp_off: begin
                    nxt_lbuf = pwdata[7:0];
                    nxt_cmp_en = 1'b0;                              // RULE9
                end
                timer_pair_pkg::ucmp_off: begin
                    nxt_ucmp = pwdata[7:0];
                    nxt_cmp_en = 1'b1;                              // RULE9
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (paddr)
                timer_pair_pkg::run_off:
                    nxt_rdata = {30'h0, urun_ff, lrun_ff};
                timer_pair_pkg::mode_off:
                    nxt_rdata = {24'h0, mode_ff};
                timer_pair_pkg::ffctl_off:
                    nxt_rdata = {27'h0, ffcfg_ff};
                timer_pair_pkg::lcmp_off:
                    nxt_rdata = {24'h0, lcmp_ff};
                timer_pair_pkg::ucmp_off:
                    nxt_rdata = {24'h0, ucmp_ff};
                timer_pair_pkg::status_off:
                    nxt_rdata = {29'h0, cmp_en_ff, 1'b0, ff_ff};
                timer_pair_pkg::count_off:
                    nxt_rdata = {16'h0, ucnt_ff, lcnt_ff};
                default:
                    nxt_rdata = 32'h0;
            endcase
        end
    end

    // without double buffer the compare follows writes directly
    logic [7:0] lcmp_sel;
    always_comb begin
        lcmp_sel = nxt_lcmp;
        if (wr && paddr == timer_pair_pkg::lcmp_off &&
            !(ffcfg_ff.dbuf_en &&
              (mode_ff.pair_mode == timer_pair_pkg::mode_ppg ||
               mode_ff.pair_mode == timer_pair_pkg::mode_pwm))) begin
            lcmp_sel = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lrun_ff     <= 1'b0;
            urun_ff     <= 1'b0;
            mode_ff     <= '0;
            ffcfg_ff    <= {1'b0, timer_pair_pkg::ffc_reset, 2'b00};
            lcmp_ff     <= timer_pair_pkg::zero8;
            lbuf_ff     <= timer_pair_pkg::zero8;
            ucmp_ff     <= timer_pair_pkg::zero8;
            lcnt_ff     <= timer_pair_pkg::zero8;
            ucnt_ff     <= timer_pair_pkg::zero8;
            cmp_en_ff   <= 1'b1;
            ff_ff       <= 1'b0;
            lirq_ff     <= 1'b0;
            uirq_ff     <= 1'b0;
            rdata_ff    <= 32'h0;
            ext_prev_ff <= 1'b0;
        end else begin
            lrun_ff     <= nxt_lrun;
            urun_ff     <= nxt_urun;
            mode_ff     <= nxt_mode;
            ffcfg_ff    <= nxt_ffcfg;
            lcmp_ff     <= lcmp_sel;
            lbuf_ff     <= nxt_lbuf;
            ucmp_ff     <= nxt_ucmp;
            lcnt_ff     <= nxt_lcnt;
            ucnt_ff     <= nxt_ucnt;
            cmp_en_ff   <= nxt_cmp_en;
            ff_ff       <= nxt_ff;
            lirq_ff     <= nxt_lirq;
            uirq_ff     <= nxt_uirq;
            rdata_ff    <= nxt_rdata;
            ext_prev_ff <= nxt_ext_prev;
        end
    end

    assign prdata           = rdata_ff;
    assign pready           = 1'b1;
    assign pslverr          = 1'b0;
    assign timer_output_pin = ff_ff;
    assign lower_timer_irq  = lirq_ff;
    assign upper_timer_irq  = uirq_ff;
endmodule
`default_nettype wire

// ===== timer_pair_properties.sv
// Purpose: port-level assertions for timer_pair
// Assumes: a write lands on psel&penable&pwrite; mode and ffctl shadowed
// Notes:   the cycle after any write is excluded from toggle checks
`timescale 1ns/1ps
`default_nettype none
module timer_pair_properties (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire timer_pair_pkg::taps_t taps,
    input wire logic                  external_clock_pin,
    input wire logic                  timer_output_pin,
    input wire logic                  lower_timer_irq,
    input wire logic                  upper_timer_irq
);
    timer_pair_pkg::mode_t  md_ff, nxt_md;
    timer_pair_pkg::ffcfg_t fc_ff, nxt_fc;
    logic                   wr, ffw, runw, wr_ff;
    logic [1:0]             pm;
    assign wr   = psel && penable && pwrite;
    assign ffw  = wr && paddr == timer_pair_pkg::ffctl_off;
    assign runw = wr && paddr == timer_pair_pkg::run_off;
    assign pm   = md_ff.pair_mode;
    always_comb begin
        nxt_md = md_ff;
        nxt_fc = fc_ff;
        if (wr && paddr == timer_pair_pkg::mode_off) nxt_md = pwdata[7:0];
        if (ffw) nxt_fc = pwdata[4:0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            md_ff <= '0;
            fc_ff <= 5'h0c;
            wr_ff <= 1'b0;
        end else begin
            md_ff <= nxt_md;
            fc_ff <= nxt_fc;
            wr_ff <= wr;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ff_set; ffw && pwdata[3:2] == 2'h1 |=> timer_output_pin;
    endproperty
    a_ff_set: assert property (p_ff_set) else $error("ff not set");
    property p_ff_clr; ffw && pwdata[3:2] == 2'h2 |=> !timer_output_pin;
    endproperty
    a_ff_clr: assert property (p_ff_clr) else $error("ff not clear");
    property p_ff_inv; ffw && pwdata[3:2] == 2'h0
        |=> timer_output_pin != $past(timer_output_pin); endproperty
    a_ff_inv: assert property (p_ff_inv) else $error("ff not inv");
    // a match on the stop edge may still show its irq one cycle later
    property p_stop; runw && pwdata[1:0] == 2'h0
        |=> ##1 (!lower_timer_irq && !upper_timer_irq) [*6]; endproperty
    a_stop: assert property (p_stop) else $error("irq after stop");
    property p_lo_quiet; pm != 2'h0 && $past(pm) != 2'h0 |-> !lower_timer_irq;
    endproperty
    a_lo_quiet: assert property (p_lo_quiet) else $error("lower irq");
    property p_up_quiet; pm == 2'h2 && $past(pm) == 2'h2 |-> !upper_timer_irq;
    endproperty
    a_up_quiet: assert property (p_up_quiet) else $error("upper irq");
    property p_src; pm == 2'h0 && fc_ff.inv_en && !wr_ff
        |-> $changed(timer_output_pin) ==
            (fc_ff.src_sel ? upper_timer_irq : lower_timer_irq); endproperty
    a_src: assert property (p_src) else $error("wrong toggle source");
    property p_joint; pm == 2'h1 && fc_ff.inv_en && !wr_ff
        |-> $changed(timer_output_pin) == upper_timer_irq; endproperty
    a_joint: assert property (p_joint) else $error("joint toggle");
endmodule
bind timer_pair timer_pair_properties u_timer_pair_properties (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .taps, .external_clock_pin, .timer_output_pin,
    .lower_timer_irq, .upper_timer_irq);
`default_nettype wire

// ===== tap_source.sv
// Purpose: prescaler taps and external clock pin for timer_pair
// Assumes: taps are one-cycle enables, tap_1 every cycle
// Notes:   the pin runs free, rising once every 8 cycles
`timescale 1ns/1ps
`default_nettype none
module tap_source (
    input  wire logic            pclk,
    input  wire logic            presetn,
    output timer_pair_pkg::taps_t taps,
    output logic                 external_clock_pin
);
    logic [7:0] cnt_ff, nxt_cnt;
    always_comb nxt_cnt = cnt_ff + 8'h01;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_ff <= 8'h00;
        else cnt_ff <= nxt_cnt;
    end
    assign taps = {1'b1, cnt_ff[1:0] == 2'h0, cnt_ff[3:0] == 4'h0,
                   cnt_ff == 8'h00};
    assign external_clock_pin = cnt_ff[2];
endmodule
`default_nettype wire

// ===== dual_8bit_timer_pair_modes_bench.sv
// Purpose: self-checking bench for timer_pair
// Assumes: tap_source feeds taps and the external clock pin
// Notes:   periods assume a match clears on the tick reaching it
`timescale 1ns/1ps
`default_nettype none
module dual_8bit_timer_pair_modes_bench;
    logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic                  penable = 1'b0, pwrite = 1'b0, pin_q = 1'b0;
    logic [11:0]           paddr = 12'h000;
    logic [31:0]           pwdata = 32'h0, prdata, rd;
    logic                  pready, pslverr, external_clock_pin;
    logic                  timer_output_pin, lower_timer_irq, upper_timer_irq;
    logic [2:0]            ev;
    timer_pair_pkg::taps_t taps;
    int                    miscompares = 0, checks_done = 0, cyc = 0;
    timer_pair u_timer_pair (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .taps,
        .external_clock_pin, .timer_output_pin, .lower_timer_irq,
        .upper_timer_irq);
    tap_source u_tap_source (.pclk, .presetn, .taps, .external_clock_pin);
    always #12.5 pclk = ~pclk;
    assign ev = {timer_output_pin & ~pin_q, upper_timer_irq, lower_timer_irq};
    always @(posedge pclk) begin
        pin_q <= timer_output_pin;
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task stop_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // stop first, then mode, ffctl, low compare, high compare, run
    task cfg(input logic [7:0] m, f, lc, uc, r);
        apb(1'b1, timer_pair_pkg::run_off, 32'h0);
        apb(1'b1, timer_pair_pkg::mode_off, {24'h0, m});
        apb(1'b1, timer_pair_pkg::ffctl_off, {24'h0, f});
        apb(1'b1, timer_pair_pkg::lcmp_off, {24'h0, lc});
        apb(1'b1, timer_pair_pkg::ucmp_off, {24'h0, uc});
        apb(1'b1, timer_pair_pkg::run_off, {24'h0, r});
    endtask
    // cycles between two events: 0 lower irq, 1 upper irq, 2 pin rise
    task gap(input int s, input int exp);
        int n;
        n = 0;
        @(posedge pclk);
        #1;
        while (ev[s] !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (ev[s] !== 1'b1 && n < 1000);
        chk(n, exp);
    endtask
    task t_regs();
        rdchk(timer_pair_pkg::mode_off, 32'h0);
        rdchk(timer_pair_pkg::ffctl_off, 32'h0c);
        rdchk(timer_pair_pkg::status_off, 32'h4);
        apb(1'b1, 12'h01c, 32'h5a);
        rdchk(12'h01c, 32'h0);
    endtask
    task t_dual();
        cfg(8'h02, 8'h0f, 8'h05, 8'h03, 8'h03);
        gap(0, 20);
        gap(1, 60);
        gap(2, 120);
        cfg(8'h08, 8'h0e, 8'h02, 8'h03, 8'h03);
        gap(0, 16);
        gap(1, 48);
        gap(2, 32);
        cfg(8'h0f, 8'h0e, 8'h02, 8'h01, 8'h03);
        gap(0, 32);
        gap(1, 256);
        apb(1'b1, timer_pair_pkg::run_off, 32'h0);
        rdchk(timer_pair_pkg::count_off, 32'h0);
    endtask
    task t_ff();
        logic [1:0] c[4];
        logic       v[4];
        c = '{timer_pair_pkg::ffc_set, timer_pair_pkg::ffc_clear,
              timer_pair_pkg::ffc_invert, timer_pair_pkg::ffc_keep};
        v = '{1'b1, 1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, timer_pair_pkg::ffctl_off, {28'h0, c[i], 2'h0});
            apb(1'b0, timer_pair_pkg::status_off, 32'h0);
            chk(rd[0], v[i]);
        end
    endtask
    task t_pwm();
        for (int k = 1; k < 4; k++) begin
            cfg({timer_pair_pkg::mode_pwm, k[1:0], 4'h1}, 8'h1e, 8'h10,
                8'h02, 8'h03);
            gap(2, 32 << k);
        end
        gap(1, 512);
        gap(2, 256);
        apb(1'b1, timer_pair_pkg::lcmp_off, 32'h20);
        rdchk(timer_pair_pkg::lcmp_off, 32'h10);
        gap(2, 256);
        rdchk(timer_pair_pkg::lcmp_off, 32'h20);
    endtask
    task t_ppg();
        cfg({timer_pair_pkg::mode_ppg, 6'h01}, 8'h1e, 8'h04, 8'h0a,
            8'h03);
        rdchk(timer_pair_pkg::lcmp_off, 32'h20);
        gap(2, 10);
        rdchk(timer_pair_pkg::lcmp_off, 32'h4);
    endtask
    task t_16();
        // upper clock field says tap_1, which this mode must ignore
        cfg({timer_pair_pkg::mode_16, 6'h05}, 8'h0e, 8'h02, 8'h01,
            8'h03);
        gap(1, 258);
        gap(2, 516);
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_dual();
        t_ff();
        t_pwm();
        t_ppg();
        t_16();
        stop_test();
    end
endmodule
`default_nettype wire
